// ==== design/bws_wait_gen.sv ====
`timescale 1ns/1ps
// Contract
// R01 - Every board access gets a switch-chosen 0, 1, 2, 4 or 8 wait states from four switches.
// R02 - A coprocessor access always gets at least two wait states.
// R03 - While the coprocessor pause input is asserted, ready is held low.
// R04 - An interrupt acknowledge cycle always gets at least two wait states.
// R05 - Board select is any chip select, the memory window or acknowledge; with pSYNC it loads.
// R06 - On load the shift output tap at once shows the inverse of the last pattern bit.
// R07 - With the first wait switch closed the last bit loads zero and ready drops at load.
// R08 - After pSYNC falls the register shifts on each bus clock falling edge until a one emerges.
// R09 - The wait length in bus clocks equals the zeros loaded at the output end.
// R10 - Coprocessor or acknowledge access forces the first two switch bits as if closed.
// R11 - Each write to the clock chip command latch holds ready low for about 6 us.
// R12 - Each write of the hold bit high holds ready low for about 150 us.
// R13 - Clock chip command and data are latched on select with write, address bit 0 picks which.
// R14 - On clock select with read and read bit set, data latch floats and the read buffer drives.
// R15 - Acknowledge indication comes from acknowledge status with valid status, suspended by hold.
// R16 - Ready is an open-collector low that any wait source can hold independently.
// R17 - Switch positions give 1, 2, 4 or 8 zeros at the output end; none gives no wait.
module bws_wait_gen
    import bws_pkg::*;
#(
    parameter logic [TMR_W-1:0] HOLD_CYC = HOLD_WAIT_CYC
) (
    input wire logic clock_i, // 40 MHz system clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic bus_clk_i, // Bus clock, sampled
    input wire bws_bus_stat_t stat_i, // Bus sync and status lines
    input wire logic [NUM_CS-1:0] chip_sel_n_i, // On-board peripheral selects
    input wire logic copro_sel_n_i, // Math coprocessor select
    input wire logic mem_sel_n_i, // Memory window select
    input wire logic clk_sel_n_i, // Clock chip select
    input wire logic copro_pause_n_i, // Coprocessor pause, low to wait
    input wire logic [NUM_SW-1:0] wait_sw_i, // Wait switches, 1 means closed
    input wire logic wr_n_i, // Board write strobe
    input wire logic rd_n_i, // Board read strobe
    input wire logic addr0_i, // Address bit 0
    input wire logic [CMD_W-1:0] data_i, // Board data bus
    output logic intack_active_n_o, // Interrupt acknowledge in progress
    output logic board_sel_o, // Board select
    output logic rdy_o, // Bus ready level, always low
    output logic rdy_oe_o, // Bus ready pull-down enable
    output bws_rtc_latch_t rtc_o, // Clock chip command and data latches
    output logic rtc_data_oe_o, // Data latch drives clock chip
    output logic rtc_rdbuf_oe_o // Clock chip read buffer drives board bus
);

    // Interrupt acknowledge tracking
    bws_ia_state_t ia_ff;
    bws_ia_state_t nxt_ia;
    logic stat_valid;
    logic ack;
    logic ack_clear;

    assign stat_valid = stat_i.psync && !stat_i.stval_n;
    // A valid non-acknowledge status ends the sequence in its own cycle, so
    // a foreign access right after an acknowledge is not claimed by the board
    assign ack_clear = stat_valid && !stat_i.sinta && !stat_i.phlda;

    always_comb begin
        nxt_ia = ia_ff;
        case (ia_ff)
            IA_IDLE: begin
                if (stat_valid && stat_i.sinta && !stat_i.phlda) begin
                    nxt_ia = IA_ACK;
                end
            end
            IA_ACK: begin
                // DMA cycles must not end an acknowledge sequence halfway
                if (ack_clear) begin
                    nxt_ia = IA_IDLE;
                end
            end
            default: nxt_ia = IA_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ia_ff <= IA_IDLE;
        end else begin
            ia_ff <= nxt_ia;
        end
    end

    // The first acknowledge cycle must count in its own sync phase
    assign ack = ((ia_ff == IA_ACK) || (stat_valid && stat_i.sinta)) && !ack_clear;
    assign intack_active_n_o = !ack || stat_i.phlda; // R15

    // Board select and pattern
    logic load;
    logic force_two;
    logic [NUM_SW-1:0] eff_sw;
    logic [SR_W-1:0] pattern;

    assign board_sel_o = !(&chip_sel_n_i) || !copro_sel_n_i || !mem_sel_n_i
        || !clk_sel_n_i || !intack_active_n_o; // R05
    assign load = board_sel_o && stat_i.psync; // R05
    assign force_two = !copro_sel_n_i || !intack_active_n_o; // R02 R04
    assign eff_sw = {wait_sw_i[3:2], wait_sw_i[1:0] | {2{force_two}}}; // R10

    genvar gi;
    generate
        for (gi = 0; gi < SR_W; gi++) begin : g_pat
            assign pattern[gi] = !(eff_sw[3] || (eff_sw[2] && gi < 4)
                || (eff_sw[1] && gi < 2) || (eff_sw[0] && gi < 1)); // R01 R17 R09
        end
    endgenerate

    // Wait shift register
    logic [SR_W-1:0] sr_ff;
    logic [SR_W-1:0] nxt_sr;
    logic bus_clk_ff;
    logic bus_fall;
    logic shift_output_tap;

    assign bus_fall = bus_clk_ff && !bus_clk_i;

    always_comb begin
        nxt_sr = sr_ff;
        if (load) begin
            nxt_sr = pattern; // R05
        end else if (!stat_i.psync && bus_fall) begin
            nxt_sr = {1'b1, sr_ff[SR_W-1:1]}; // R08
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sr_ff <= SR_RST;
            bus_clk_ff <= 1'b0;
        end else begin
            sr_ff <= nxt_sr;
            bus_clk_ff <= bus_clk_i;
        end
    end

    // During load the tap follows the pattern at once, not a cycle later
    assign shift_output_tap = load ? !pattern[0] : !sr_ff[0]; // R06 R07 R09

    // Clock chip latches
    logic wr_strb;
    logic wr_strb_ff;
    logic wr_start;
    logic cmd_start;
    logic hold_start;
    logic rd_active;
    bws_rtc_latch_t rtc_ff;
    bws_rtc_latch_t nxt_rtc;

    assign wr_strb = !clk_sel_n_i && !wr_n_i;
    assign wr_start = wr_strb && !wr_strb_ff;
    assign cmd_start = wr_start && (addr0_i == ADDR0_CMD);
    assign hold_start = cmd_start && data_i[CMD_HOLD_BIT];

    always_comb begin
        nxt_rtc = rtc_ff;
        if (wr_start) begin
            if (addr0_i == ADDR0_CMD) begin
                nxt_rtc.cmd = data_i; // R13
            end else begin
                nxt_rtc.data = data_i[DAT_W-1:0]; // R13
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rtc_ff <= '{cmd: CMD_RST, data: DAT_RST};
            wr_strb_ff <= 1'b0;
        end else begin
            rtc_ff <= nxt_rtc;
            wr_strb_ff <= wr_strb;
        end
    end

    assign rtc_o = rtc_ff;
    // Software must set the read bit first, otherwise the latch keeps driving
    assign rd_active = !clk_sel_n_i && !rd_n_i && rtc_ff.cmd[CMD_READ_BIT]; // R14
    assign rtc_data_oe_o = !rd_active; // R14
    assign rtc_rdbuf_oe_o = rd_active; // R14

    // Timed waits for the slow clock chip
    logic cmd_busy;
    logic hold_busy;

    bws_oneshot #(
        .CYC(CMD_WAIT_CYC)
    ) u_cmd_wait (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .trig_i(cmd_start), // R11
        .busy_o(cmd_busy)
    );

    bws_oneshot #(
        .CYC(HOLD_CYC)
    ) u_hold_wait (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .trig_i(hold_start), // R12
        .busy_o(hold_busy)
    );

    // Ready: wired-OR of independent pull-downs
    assign rdy_o = 1'b0; // R16
    assign rdy_oe_o = shift_output_tap || cmd_start || cmd_busy || hold_busy
        || !copro_pause_n_i; // R16 R03 R11 R12

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    property p_copro_two;
        load && !copro_sel_n_i |=> (sr_ff[1:0] == 2'b00);
    endproperty
    a_copro_two: assert property (p_copro_two) else $error("coprocessor wait short"); // R02

    property p_ack_two;
        load && !intack_active_n_o |=> (sr_ff[1:0] == 2'b00);
    endproperty
    a_ack_two: assert property (p_ack_two) else $error("acknowledge wait short"); // R04

    property p_pause;
        !copro_pause_n_i |-> rdy_oe_o && !rdy_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause did not hold ready"); // R03

    property p_no_wait;
        load && (wait_sw_i == 4'h0) && !force_two |-> !shift_output_tap;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("wait without switches"); // R06

    property p_first_sw;
        load && wait_sw_i[0] |-> rdy_oe_o ##1 (sr_ff[0] == 1'b0);
    endproperty
    a_first_sw: assert property (p_first_sw) else $error("first switch no wait"); // R07

    property p_eight;
        load && wait_sw_i[3] |=> (sr_ff == 8'h00);
    endproperty
    a_eight: assert property (p_eight) else $error("eight waits not loaded"); // R17

    property p_shift;
        !stat_i.psync && bus_fall |=> (sr_ff == {1'b1, $past(sr_ff[SR_W-1:1])});
    endproperty
    a_shift: assert property (p_shift) else $error("shift step wrong"); // R08

    property p_cmd_wait;
        cmd_start |-> rdy_oe_o ##1 rdy_oe_o [*8];
    endproperty
    a_cmd_wait: assert property (p_cmd_wait) else $error("command wait missing"); // R11

    property p_hold_wait;
        hold_start |=> hold_busy [*8];
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("hold wait missing"); // R12

    property p_latch;
        wr_start && (addr0_i == ADDR0_CMD) |=> (rtc_o.cmd == $past(data_i));
    endproperty
    a_latch: assert property (p_latch) else $error("command not latched"); // R13

    property p_read;
        !clk_sel_n_i && !rd_n_i && rtc_o.cmd[CMD_READ_BIT] |-> rtc_rdbuf_oe_o && !rtc_data_oe_o;
    endproperty
    a_read: assert property (p_read) else $error("read path wrong"); // R14

    property p_hlda;
        stat_i.phlda |-> intack_active_n_o;
    endproperty
    a_hlda: assert property (p_hlda) else $error("acknowledge during hold"); // R15

    property p_ack_clear;
        stat_valid && !stat_i.sinta && !stat_i.phlda |-> intack_active_n_o;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge not cleared"); // R15

    property p_ack_keep;
        (ia_ff == IA_ACK) && !stat_valid && !stat_i.phlda |-> !intack_active_n_o;
    endproperty
    a_ack_keep: assert property (p_ack_keep) else $error("acknowledge dropped early"); // R15

    property p_no_shift_sync;
        stat_i.psync && !load |=> $stable(sr_ff);
    endproperty
    a_no_shift_sync: assert property (p_no_shift_sync) else $error("shift during sync"); // R08

    property p_wait_done;
        !stat_i.psync && bus_fall && (sr_ff[1:0] == 2'b10) |=> sr_ff[0];
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("wait did not end"); // R09

    property p_latch_data;
        wr_start && (addr0_i != ADDR0_CMD) |=> (rtc_o.data == $past(data_i[DAT_W-1:0]));
    endproperty
    a_latch_data: assert property (p_latch_data) else $error("data not latched"); // R13

    c_copro: cover property (load && !copro_sel_n_i ##1 !load [*2]);
    c_ack: cover property (stat_valid && stat_i.sinta ##1 ia_ff == IA_ACK);
    c_hold: cover property (hold_start ##1 hold_busy);
    c_eight: cover property (load && wait_sw_i[3] ##1 !load [*8]);
    c_read: cover property (rtc_rdbuf_oe_o);

endmodule : bws_wait_gen

// ==== design/bws_pkg.sv ====
package bws_pkg;

    // Timing at a 40 MHz system clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int CMD_WAIT_NS = 6000;
    localparam int HOLD_WAIT_NS = 150000;
    localparam int TMR_W = 16;
    // Least times round up to whole cycles
    localparam logic [TMR_W-1:0] CMD_WAIT_CYC =
        TMR_W'((CMD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] HOLD_WAIT_CYC =
        TMR_W'((HOLD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Wait shift register, bit 0 is the output end
    localparam int SR_W = 8;
    localparam logic [SR_W-1:0] SR_RST = 8'hff;
    localparam int NUM_SW = 4;
    localparam int NUM_CS = 6;

    // Clock chip latches
    localparam int CMD_W = 8;
    localparam int DAT_W = 4;
    localparam int CMD_HOLD_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam logic ADDR0_CMD = 1'b1;
    localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
    localparam logic [DAT_W-1:0] DAT_RST = 4'h0;

    typedef enum logic [1:0] {
        IA_IDLE = 2'b01,
        IA_ACK = 2'b10
    } bws_ia_state_t;

    typedef struct packed {
        logic psync;
        logic stval_n;
        logic sinta;
        logic phlda;
    } bws_bus_stat_t;

    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [DAT_W-1:0] data;
    } bws_rtc_latch_t;

endpackage : bws_pkg

// ==== design/bws_oneshot.sv ====
`timescale 1ns/1ps
module bws_oneshot
    import bws_pkg::*;
#(
    parameter logic [TMR_W-1:0] CYC = CMD_WAIT_CYC
) (
    input wire logic clock_i, // System clock
    input wire logic srst_i, // Synchronous reset
    input wire logic trig_i, // Start or restart pulse
    output logic busy_o // High for CYC cycles after a trigger
);

    logic [TMR_W-1:0] cnt_ff;
    logic [TMR_W-1:0] nxt_cnt;

    // A retrigger restarts the full interval, like a retriggerable one-shot
    always_comb begin
        nxt_cnt = cnt_ff;
        if (trig_i) begin
            nxt_cnt = CYC;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - TMR_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy_o = (cnt_ff != '0);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    property p_os_load;
        trig_i |=> (cnt_ff == CYC);
    endproperty
    a_os_load: assert property (p_os_load) else $error("one-shot did not load"); // R11

    property p_os_run;
        (cnt_ff > TMR_W'(1)) && !trig_i |=> busy_o && (cnt_ff == $past(cnt_ff) - TMR_W'(1));
    endproperty
    a_os_run: assert property (p_os_run) else $error("one-shot did not count"); // R12

endmodule : bws_oneshot

// ==== testbench/bws_cpu_model.sv ====
`timescale 1ns/1ps
module bws_cpu_model
    import bws_pkg::*;
#(
    parameter int DIV = 2
) (
    input wire logic clock_i, // System clock
    output logic bus_clk_o, // Bus clock
    output bws_bus_stat_t stat_o // Sync and status
);
    int div_cnt = 0;
    initial begin
        bus_clk_o = 1'b0;
        stat_o = '{1'b0, 1'b1, 1'b0, 1'b0};
    end
    // Bus clock runs free, as on the backplane
    always @(posedge clock_i) begin
        div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
        if (div_cnt == DIV - 1) begin
            bus_clk_o <= ~bus_clk_o;
        end
    end
    task automatic start(input logic inta);
        @(posedge clock_i);
        stat_o.psync <= 1'b1;
        stat_o.stval_n <= 1'b0;
        stat_o.sinta <= inta;
    endtask : start
    // Status is invalid outside sync, so the status line is flipped
    task automatic stop();
        @(posedge clock_i);
        stat_o.psync <= 1'b0;
        stat_o.stval_n <= 1'b1;
        stat_o.sinta <= ~stat_o.sinta;
    endtask : stop
    task automatic hold(input logic v);
        @(posedge clock_i);
        stat_o.phlda <= v;
    endtask : hold
endmodule : bws_cpu_model

// ==== testbench/board_wait_state_generator_tb.sv ====
`timescale 1ns/1ps
module board_wait_state_generator_tb import bws_pkg::*; ;
    localparam int HOLD = 300;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic bus_clk;
    bws_bus_stat_t stat;
    logic [NUM_CS-1:0] cs_n = '1;
    logic copro_n = 1'b1;
    logic mem_n = 1'b1;
    logic clk_n = 1'b1;
    logic pause_n = 1'b1;
    logic [NUM_SW-1:0] sw = '0;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic a0 = 1'b0;
    logic [CMD_W-1:0] data = '0;
    logic ia_n, bsel, rdy, rdy_oe, d_oe, rb_oe;
    bws_rtc_latch_t rtc;
    bws_rtc_latch_t exp_rtc = '0;
    int errors = 0;
    int n_compared = 0;

    initial forever #12.5 clock_i = ~clock_i;

    bws_cpu_model cpu (.clock_i(clock_i), .bus_clk_o(bus_clk), .stat_o(stat));

    bws_wait_gen #(.HOLD_CYC(16'h012c)) uut (
        .clock_i(clock_i), .srst_i(srst_i), .bus_clk_i(bus_clk), .stat_i(stat),
        .chip_sel_n_i(cs_n), .copro_sel_n_i(copro_n), .mem_sel_n_i(mem_n),
        .clk_sel_n_i(clk_n), .copro_pause_n_i(pause_n), .wait_sw_i(sw),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .addr0_i(a0), .data_i(data),
        .intack_active_n_o(ia_n), .board_sel_o(bsel), .rdy_o(rdy), .rdy_oe_o(rdy_oe),
        .rtc_o(rtc), .rtc_data_oe_o(d_oe), .rtc_rdbuf_oe_o(rb_oe));

    task automatic complete_run();
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int exp, input string m);
        n_compared++;
        if (got != exp) begin
            errors++;
            $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask : chk_n

    function automatic int zeros(input logic [3:0] s, input bit frc);
        int z;
        z = s[3] ? 8 : s[2] ? 4 : s[1] ? 2 : s[0] ? 1 : 0;
        return (frc && z < 2) ? 2 : z;
    endfunction : zeros

    task automatic access(input logic inta, input int exp_n);
        logic prev;
        int n;
        n = 0;
        cpu.start(inta);
        #1;
        chk(rdy_oe, exp_n != 0, "load ready");
        chk(bsel, 1'b1, "board select");
        chk(ia_n, !inta, "ack flag");
        prev = bus_clk;
        cpu.stop();
        repeat (100) begin
            #1;
            if (rdy_oe !== 1'b1) break;
            if (prev && !bus_clk) n++;
            prev = bus_clk;
            @(posedge clock_i);
        end
        chk_n(n, exp_n, "wait length");
    endtask : access

    task automatic rtc_wr(input logic a, input logic [7:0] d, input int exp_n);
        int n;
        @(posedge clock_i);
        clk_n <= 1'b0;
        wr_n <= 1'b0;
        a0 <= a;
        data <= d;
        #1;
        n = (rdy_oe === 1'b1);
        @(posedge clock_i);
        clk_n <= 1'b1;
        wr_n <= 1'b1;
        data <= ~d;
        if (a) exp_rtc.cmd = d;
        else exp_rtc.data = d[3:0];
        #1;
        while (rdy_oe === 1'b1 && n < 2000) begin
            n++;
            @(posedge clock_i);
            #1;
        end
        chk_n(n, exp_n, "clock chip wait");
        chk(rtc, exp_rtc, "latches");
    endtask : rtc_wr

    initial begin
        logic [7:0] d;
        logic [NUM_SW-1:0] s;
        void'($urandom(45));
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk({rdy, rdy_oe, ia_n, rtc}, 16'h1000, "idle");
        // Sources 0-5 peripherals, 6 coprocessor, 7 memory window
        for (int k = 0; k < 24; k++) begin
            @(posedge clock_i);
            s = (k < 16) ? NUM_SW'(k) : NUM_SW'($urandom_range(15));
            sw <= s;
            if (k % 8 < NUM_CS) cs_n[k % 8] <= 1'b0;
            copro_n <= (k % 8 != 6);
            mem_n <= (k % 8 != 7);
            access(1'b0, zeros(s, k % 8 == 6));
            @(posedge clock_i);
            cs_n <= '1;
            copro_n <= 1'b1;
            mem_n <= 1'b1;
        end
        @(posedge clock_i);
        s = NUM_SW'($urandom_range(15));
        sw <= s;
        access(1'b1, zeros(s, 1'b1));
        cpu.hold(1'b1);
        #1;
        chk(ia_n, 1'b1, "ack under hold");
        cpu.hold(1'b0);
        #1;
        chk(ia_n, 1'b0, "ack resumes");
        @(posedge clock_i);
        mem_n <= 1'b0;
        sw <= 4'hf;
        access(1'b0, 8);
        @(posedge clock_i);
        mem_n <= 1'b1;
        #1;
        chk(ia_n, 1'b1, "ack cleared");
        @(posedge clock_i);
        pause_n <= 1'b0;
        #1;
        chk(rdy_oe, 1'b1, "pause wait");
        @(posedge clock_i);
        pause_n <= 1'b1;
        #1;
        chk(rdy_oe, 1'b0, "pause end");
        // Bit 0 hold, bit 1 read enable
        for (int k = 0; k < 4; k++) begin
            d = {6'($urandom_range(63)), 2'(k)};
            rtc_wr(1'b1, d, 1 + ((d[0] && HOLD > CMD_WAIT_CYC) ? HOLD : CMD_WAIT_CYC));
            @(posedge clock_i);
            clk_n <= 1'b0;
            rd_n <= 1'b0;
            #1;
            chk({rb_oe, d_oe}, {d[1], !d[1]}, "read path");
            @(posedge clock_i);
            clk_n <= 1'b1;
            rd_n <= 1'b1;
        end
        rtc_wr(1'b0, 8'($urandom), 0);
        complete_run();
    end

    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end
endmodule : board_wait_state_generator_tb
